// ### design/lis_cfg.svh
// numeric configuration of the line interface state control
// assumes a 10 MHz system clock; included by the package and the design
`ifndef LIS_CFG_SVH
`define LIS_CFG_SVH

`define LIS_CODE_W        3
`define LIS_TSEL_W        3
`define LIS_CTRL_W        6
`define LIS_SYNC_W        13
`define LIS_OVL_W         4

// synchroniser vector layout
`define LIS_SY_BAT_OK     0
`define LIS_SY_THERM      1
`define LIS_SY_GND        2
`define LIS_SY_RTRIP      3
`define LIS_SY_LOOP       4
`define LIS_SY_DRST_N     5
`define LIS_SY_STROBE     6
`define LIS_SY_CODE_LSB   7
`define LIS_SY_TSEL_LSB   10
`define LIS_SYNC_RST      13'h0040

// line state codes on the control bus
`define LIS_CODE_DISC     3'h0
`define LIS_CODE_FWD      3'h1
`define LIS_CODE_REV      3'h2
`define LIS_CODE_SCAN     3'h3
`define LIS_CODE_RING     3'h4
`define LIS_CODE_TIPOPEN  3'h5

// test selections; 1..6 are the line measurements
`define LIS_TSEL_NONE     3'h0
`define LIS_TSEL_VREF     3'h7

// make-before-break overlap of ringing and line break switches
`define LIS_CLK_PERIOD_NS 100
`define LIS_MBB_TIME_NS   1000
`define LIS_MBB_CYC       ((`LIS_MBB_TIME_NS + `LIS_CLK_PERIOD_NS - 1) / `LIS_CLK_PERIOD_NS)

`endif

// ### design/lis_pkg.sv
// types of the line interface state control
// assumes lis_cfg.svh is on the include path
`include "lis_cfg.svh"

package lis_pkg;

    typedef enum logic [5:0] {
        LIS_M_DISC    = 6'h01,
        LIS_M_FWD     = 6'h02,
        LIS_M_REV     = 6'h04,
        LIS_M_SCAN    = 6'h08,
        LIS_M_RING    = 6'h10,
        LIS_M_TIPOPEN = 6'h20
    } lis_mode_t;

    typedef struct packed {
        logic scan_clamp;
        logic loop_det;
        logic thermal;
        logic low_batt;
        logic ac_tx;
        logic dc_feed;
        logic ring_trip;
        logic onhook_tx;
        logic tr_drive;
        logic cm_det;
        logic tip_open;
        logic polarity_rev;
        logic test_path;
        logic test_tone;
        logic test_level_oe;
    } lis_en_t;

    typedef struct packed {
        logic                   strobe_d;
        lis_mode_t              mode;
        logic [`LIS_TSEL_W-1:0] tsel;
        logic                   line_sw;
        logic                   ring_sw;
        logic [`LIS_OVL_W-1:0]  ovl_cnt;
        lis_en_t                en;
        logic                   status_n;
    } lis_state_t;

endpackage : lis_pkg

// ### design/lis_sync.sv
// two-stage synchroniser for every pin input of the line control
// assumes single clock clk and asynchronous active-high rst
`include "lis_cfg.svh"

module lis_sync (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [`LIS_SYNC_W-1:0] d,
    output logic      [`LIS_SYNC_W-1:0] q
);
    import lis_pkg::*;

    typedef struct packed {
        logic [`LIS_SYNC_W-1:0] meta;
        logic [`LIS_SYNC_W-1:0] stable;
    } lis_sync_t;

    lis_sync_t s_reg;
    lis_sync_t s_next;

    // first stage feeds only the second stage
    always_comb begin
        s_next.meta   = d;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= {`LIS_SYNC_RST, `LIS_SYNC_RST};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;

endmodule : lis_sync

// ### design/lis_line_ctrl.sv
// line interface state control: latched control bus, mode decode,
// detector and switch enables, supervision status output
// assumes pins arrive asynchronously and are synchronised here
//
// Function
// RULE1: capture control bus on strobe falling edge
// RULE2: host keeps bus stable while strobe low
// RULE3: reset pin forces disconnect, switches off
// RULE4: reset pin forces status to on-hook
// RULE5: disconnect turns all off, reports on-hook
// RULE6: scan keeps clamp, loop, thermal, battery only
// RULE7: ring closes ring switch, ring trip only; code also keeps thermal and battery shutdown on
// RULE8: direct ring changes make before break
// RULE9: host uses disconnect for break before make
// RULE10: unlatched active-low status, hook or trip
// RULE11: forward and reverse both transmit, ac kept
// RULE12: tip open state with common-mode detector
// RULE13: test tone enabled in test states
// RULE14: test tone off outside test and reference
// RULE15: test level output off outside test
// RULE16: test selection leaves line state unchanged
// RULE17: reference test routes reference to output
// RULE18: overheat forces all-off, off-hook, then resumes
// RULE19: battery out of window forces all-off, off-hook
// RULE20: control code decoded to one mode
`include "lis_cfg.svh"

module lis_line_ctrl (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [`LIS_CODE_W-1:0] ctrl_code,
    input  wire logic [`LIS_TSEL_W-1:0] ctrl_test_sel,
    input  wire logic                   latch_strobe_n,
    input  wire logic                   dev_reset_n,
    input  wire logic                   loop_closure_det,
    input  wire logic                   ring_trip_det,
    input  wire logic                   ground_key_det,
    input  wire logic                   thermal_hot,
    input  wire logic                   battery_in_window,
    output lis_pkg::lis_mode_t          line_mode,
    output logic                        supervision_status_n,
    output logic                        line_break_sw_on,
    output logic                        ring_access_sw_on,
    output logic                        scan_clamp_en,
    output logic                        loop_det_en,
    output logic                        thermal_sd_en,
    output logic                        low_batt_sd_en,
    output logic                        ac_tx_en,
    output logic                        dc_feed_en,
    output logic                        ring_trip_en,
    output logic                        onhook_tx_en,
    output logic                        tr_drive_en,
    output logic                        cm_det_en,
    output logic                        tip_open_en,
    output logic                        polarity_rev,
    output logic                        test_path_en,
    output logic                        test_tone_input_en,
    output logic                        test_level_output_oe,
    output logic      [`LIS_TSEL_W-1:0] test_level_sel
);
    import lis_pkg::*;

    localparam logic [`LIS_OVL_W-1:0] MBB_CYC = `LIS_OVL_W'(`LIS_MBB_CYC);

    lis_state_t             s_reg;
    lis_state_t             s_next;
    logic [`LIS_SYNC_W-1:0] pins_raw;
    logic [`LIS_SYNC_W-1:0] pins_s;
    logic [`LIS_CODE_W-1:0] code_s;
    logic [`LIS_TSEL_W-1:0] tsel_s;
    logic                   strobe_s;
    logic                   drst_n_s;
    logic                   all_off;
    logic                   force_off;
    lis_mode_t              eff_mode;
    logic                   tgt_line;
    logic                   tgt_ring;

    // RULE20 code decode
    function automatic lis_mode_t decode_mode(input logic [`LIS_CODE_W-1:0] code);
        lis_mode_t m;
        case (code)
            `LIS_CODE_FWD:     m = LIS_M_FWD;
            `LIS_CODE_REV:     m = LIS_M_REV;
            `LIS_CODE_SCAN:    m = LIS_M_SCAN;
            `LIS_CODE_RING:    m = LIS_M_RING;
            `LIS_CODE_TIPOPEN: m = LIS_M_TIPOPEN;
            // unused codes fall back to the safe state
            default:           m = LIS_M_DISC;
        endcase
        return m;
    endfunction : decode_mode

    function automatic lis_en_t mode_en(input lis_mode_t m,
                                        input logic [`LIS_TSEL_W-1:0] ts);
        lis_en_t e;
        logic    test;
        e    = '0;
        test = (ts != `LIS_TSEL_NONE);
        unique case (m)
            // RULE5 disconnect all off
            LIS_M_DISC: begin
                e = '0;
            end
            // RULE11 both polarities transmit
            LIS_M_FWD, LIS_M_REV: begin
                e.loop_det     = 1'b1;
                e.thermal      = 1'b1;
                e.low_batt     = 1'b1;
                e.ac_tx        = 1'b1;
                e.dc_feed      = 1'b1;
                e.onhook_tx    = 1'b1;
                e.tr_drive     = 1'b1;
                e.polarity_rev = (m == LIS_M_REV);
            end
            // RULE6 scan subset
            LIS_M_SCAN: begin
                e.scan_clamp = 1'b1;
                e.loop_det   = 1'b1;
                e.thermal    = 1'b1;
                e.low_batt   = 1'b1;
            end
            // RULE7 ring trip, plus thermal and battery
            LIS_M_RING: begin
                e.ring_trip = 1'b1;
                e.thermal   = 1'b1;
                e.low_batt  = 1'b1;
            end
            // RULE12 tip open detector
            LIS_M_TIPOPEN: begin
                e.cm_det   = 1'b1;
                e.tip_open = 1'b1;
                e.dc_feed  = 1'b1;
                e.thermal  = 1'b1;
                e.low_batt = 1'b1;
            end
        endcase
        // RULE16 test rides on line state
        if (test && (m == LIS_M_FWD || m == LIS_M_REV || m == LIS_M_TIPOPEN)) begin
            e.test_path     = 1'b1;
            // RULE15 output only in test
            e.test_level_oe = 1'b1;
            // RULE13 tone in test states
            // RULE14 not in reference test
            e.test_tone     = (ts != `LIS_TSEL_VREF);
        end
        return e;
    endfunction : mode_en

    // switch path per mode: {line break, ringing access}
    function automatic logic [1:0] path_for(input lis_mode_t m);
        logic [1:0] p;
        p = 2'h0;
        unique case (m)
            LIS_M_DISC: p = 2'h0;
            LIS_M_RING: p = 2'h1;
            // tip open still needs the line break path
            LIS_M_FWD, LIS_M_REV, LIS_M_SCAN, LIS_M_TIPOPEN: begin
                p = 2'h2;
            end
        endcase
        return p;
    endfunction : path_for

    // RULE10 live detector per mode
    function automatic logic status_for(input lis_mode_t m,
                                        input logic      loop,
                                        input logic      trip,
                                        input logic      gnd);
        logic st;
        st = 1'b1;
        unique case (m)
            // RULE5 disconnect reads on-hook
            LIS_M_DISC:    st = 1'b1;
            LIS_M_RING:    st = !trip;
            LIS_M_TIPOPEN: st = !gnd;
            LIS_M_FWD, LIS_M_REV, LIS_M_SCAN: begin
                st = !loop;
            end
        endcase
        return st;
    endfunction : status_for

    assign pins_raw = {ctrl_test_sel, ctrl_code, latch_strobe_n, dev_reset_n,
                       loop_closure_det, ring_trip_det, ground_key_det,
                       thermal_hot, battery_in_window};

    lis_sync u_sync (
        .clk (clk),
        .rst (rst),
        .d   (pins_raw),
        .q   (pins_s)
    );

    assign code_s   = pins_s[`LIS_SY_CODE_LSB +: `LIS_CODE_W];
    assign tsel_s   = pins_s[`LIS_SY_TSEL_LSB +: `LIS_TSEL_W];
    assign strobe_s = pins_s[`LIS_SY_STROBE];
    assign drst_n_s = pins_s[`LIS_SY_DRST_N];

    always_comb begin
        s_next          = s_reg;
        s_next.strobe_d = strobe_s;
        // RULE3 reset pin overrides inputs
        if (!drst_n_s) begin
            s_next.mode = LIS_M_DISC;
            s_next.tsel = `LIS_TSEL_NONE;
        // RULE1 falling strobe capture
        // RULE2 bus still stable here
        end else if (s_reg.strobe_d && !strobe_s) begin
            s_next.mode = decode_mode(code_s);
            s_next.tsel = tsel_s;
        end

        // captured mode is untouched so cooling resumes it
        // RULE18 overheat override, mode kept
        // RULE19 battery window override
        all_off   = pins_s[`LIS_SY_THERM] || !pins_s[`LIS_SY_BAT_OK];
        force_off = all_off || !drst_n_s;
        eff_mode  = force_off ? LIS_M_DISC : s_next.mode;

        {tgt_line, tgt_ring} = path_for(eff_mode);

        // RULE3 switches all off
        // RULE5 disconnect cuts any overlap
        if (force_off || eff_mode == LIS_M_DISC) begin
            s_next.line_sw = 1'b0;
            s_next.ring_sw = 1'b0;
            s_next.ovl_cnt = '0;
        end else if (s_reg.ovl_cnt > `LIS_OVL_W'(1)) begin
            // RULE8 hold overlap
            // a command other than disconnect landing mid-overlap waits for the count
            s_next.ovl_cnt = s_reg.ovl_cnt - `LIS_OVL_W'(1);
        end else if (s_reg.ovl_cnt == `LIS_OVL_W'(1)) begin
            s_next.ovl_cnt = '0;
            s_next.line_sw = tgt_line;
            s_next.ring_sw = tgt_ring;
        end else if (s_reg.line_sw != tgt_line && s_reg.ring_sw != tgt_ring &&
                     tgt_line != tgt_ring) begin
            // RULE8 make new path first
            s_next.line_sw = 1'b1;
            s_next.ring_sw = 1'b1;
            s_next.ovl_cnt = MBB_CYC;
        end else begin
            // RULE9 via disconnect no overlap
            s_next.line_sw = tgt_line;
            s_next.ring_sw = tgt_ring;
        end

        s_next.en = force_off ? '0 : mode_en(eff_mode, s_next.tsel);

        // RULE10 live detector, no latch
        if (!drst_n_s) begin
            // RULE4 on-hook in reset
            s_next.status_n = 1'b1;
        end else if (all_off) begin
            // RULE18 forced off-hook
            s_next.status_n = 1'b0;
        end else begin
            s_next.status_n = status_for(eff_mode, pins_s[`LIS_SY_LOOP],
                                         pins_s[`LIS_SY_RTRIP], pins_s[`LIS_SY_GND]);
        end
    end

    // safe disconnect state out of reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg          <= '0;
            s_reg.strobe_d <= 1'b1;
            s_reg.mode     <= LIS_M_DISC;
            s_reg.tsel     <= `LIS_TSEL_NONE;
            s_reg.status_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign line_mode            = s_reg.mode;
    assign supervision_status_n = s_reg.status_n;
    assign line_break_sw_on     = s_reg.line_sw;
    assign ring_access_sw_on    = s_reg.ring_sw;

    assign scan_clamp_en        = s_reg.en.scan_clamp;
    assign loop_det_en          = s_reg.en.loop_det;
    assign thermal_sd_en        = s_reg.en.thermal;
    assign low_batt_sd_en       = s_reg.en.low_batt;
    assign ac_tx_en             = s_reg.en.ac_tx;
    assign dc_feed_en           = s_reg.en.dc_feed;
    assign ring_trip_en         = s_reg.en.ring_trip;
    assign onhook_tx_en         = s_reg.en.onhook_tx;
    assign tr_drive_en          = s_reg.en.tr_drive;
    assign cm_det_en            = s_reg.en.cm_det;
    assign tip_open_en          = s_reg.en.tip_open;
    assign polarity_rev         = s_reg.en.polarity_rev;

    assign test_path_en         = s_reg.en.test_path;
    assign test_tone_input_en   = s_reg.en.test_tone;
    assign test_level_output_oe = s_reg.en.test_level_oe;
    // RULE17 selection 7 routes reference
    assign test_level_sel       = s_reg.en.test_path ? s_reg.tsel : `LIS_TSEL_NONE;

endmodule : lis_line_ctrl

// ### verification/lis_line_ctrl_properties.sv
// port checker of the line interface state control
// assumes lis_pkg and lis_cfg.svh are compiled first; bound to lis_line_ctrl
`include "lis_cfg.svh"

module lis_line_ctrl_chk
    import lis_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   dev_reset_n,
    input wire logic                   loop_closure_det,
    input lis_pkg::lis_mode_t          line_mode,
    input wire logic                   supervision_status_n,
    input wire logic                   line_break_sw_on,
    input wire logic                   ring_access_sw_on,
    input wire logic                   loop_det_en,
    input wire logic                   ac_tx_en,
    input wire logic                   dc_feed_en,
    input wire logic                   ring_trip_en,
    input wire logic                   onhook_tx_en,
    input wire logic                   tr_drive_en,
    input wire logic                   test_path_en,
    input wire logic                   test_tone_input_en,
    input wire logic                   test_level_output_oe,
    input wire logic [`LIS_TSEL_W-1:0] test_level_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_dev_reset;
        !dev_reset_n [*3] |=> line_mode == LIS_M_DISC && supervision_status_n
            && !line_break_sw_on && !ring_access_sw_on;
    endproperty
    a_dev_reset: assert property (p_dev_reset) else $error("device reset not safe");

    property p_disc_off;
        line_mode == LIS_M_DISC |-> !dc_feed_en && !ac_tx_en && !tr_drive_en && !loop_det_en
            && !line_break_sw_on && !ring_access_sw_on;
    endproperty
    a_disc_off: assert property (p_disc_off) else $error("disconnect left a circuit on");

    property p_scan_off;
        line_mode == LIS_M_SCAN |-> !ac_tx_en && !dc_feed_en && !ring_trip_en && !onhook_tx_en;
    endproperty
    a_scan_off: assert property (p_scan_off) else $error("scan left a circuit on");

    property p_ring_only;
        line_mode == LIS_M_RING |-> !loop_det_en && !tr_drive_en && !ac_tx_en && !dc_feed_en;
    endproperty
    a_ring_only: assert property (p_ring_only) else $error("ring left a detector on");

    // overlap must last, a glitch-free swap would be break before make
    property p_mbb_hold;
        $rose(ring_access_sw_on) && line_break_sw_on |->
            (ring_access_sw_on && line_break_sw_on) [*8];
    endproperty
    a_mbb_hold: assert property (p_mbb_hold) else $error("switch overlap too short");

    property p_status_follow;
        (line_mode == LIS_M_FWD && dc_feed_en) [*4] |->
            supervision_status_n == !$past(loop_closure_det, 3);
    endproperty
    a_status_follow: assert property (p_status_follow) else $error("status not live");

    property p_level_hiz;
        !test_path_en |-> !test_level_output_oe && !test_tone_input_en && test_level_sel == 0;
    endproperty
    a_level_hiz: assert property (p_level_hiz) else $error("test output active");

    property p_vref_tone;
        test_level_sel == `LIS_TSEL_VREF |-> !test_tone_input_en;
    endproperty
    a_vref_tone: assert property (p_vref_tone) else $error("tone on in reference");
endmodule : lis_line_ctrl_chk

bind lis_line_ctrl lis_line_ctrl_chk lis_line_ctrl_chk_i (.clk, .rst, .dev_reset_n,
    .loop_closure_det, .line_mode, .supervision_status_n, .line_break_sw_on,
    .ring_access_sw_on, .loop_det_en, .ac_tx_en, .dc_feed_en, .ring_trip_en, .onhook_tx_en,
    .tr_drive_en, .test_path_en, .test_tone_input_en, .test_level_output_oe, .test_level_sel);

// ### verification/lis_host_model.sv
// host controller model driving the latched parallel control bus
// assumes one clock; the bench calls send from its main process
`include "lis_cfg.svh"

module lis_host_model (
    input  wire logic                   clk,
    output logic      [`LIS_CODE_W-1:0] ctrl_code,
    output logic      [`LIS_TSEL_W-1:0] ctrl_test_sel,
    output logic                        latch_strobe_n
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        ctrl_code = 3'h0;
        ctrl_test_sel = 3'h0;
        latch_strobe_n = 1'b1;
    end

    task automatic send(input logic [2:0] c, input logic [2:0] t, input int low_cyc);
        @(posedge clk);
        ctrl_code <= c;
        ctrl_test_sel <= t;
        repeat (3) @(posedge clk);
        latch_strobe_n <= 1'b0;
        repeat (low_cyc) @(posedge clk);
        latch_strobe_n <= 1'b1;
        @(posedge clk);
        // shared bus: other lines' data appears once strobe is high
        ctrl_code <= ~c;
        ctrl_test_sel <= ~t;
        repeat (2) @(posedge clk);
    endtask : send
endmodule : lis_host_model

// ### verification/lis_line_ctrl_tb.sv
// self-checking bench of the line interface state control
// assumes the package, checker and host model are compiled first
`include "lis_cfg.svh"
`define CHK(o, e) begin n_checks++; if ((o) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (o), (e)); end end

module lis_line_ctrl_tb
    import lis_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0, rst = 1'b1, dev_reset_n = 1'b1, latch_strobe_n;
    logic loop_closure_det = 1'b0, ring_trip_det = 1'b0, ground_key_det = 1'b0;
    logic thermal_hot = 1'b0, battery_in_window = 1'b1;
    logic [2:0]  ctrl_code, ctrl_test_sel;
    lis_mode_t   line_mode;
    logic        supervision_status_n, line_break_sw_on, ring_access_sw_on, scan_clamp_en;
    logic        ring_trip_en, dc_feed_en, ac_tx_en, tr_drive_en, polarity_rev, cm_det_en;
    logic        test_tone_input_en, test_level_output_oe, loop_det_en, thermal_sd_en;
    logic        low_batt_sd_en, onhook_tx_en, tip_open_en, test_path_en;
    logic [2:0]  test_level_sel;
    logic [26:0] obs;
    logic [53:0] notes_q[$];
    int          mismatches = 0, n_checks = 0;
    event        smp;
    logic [2:0]  seq [13] = '{1, 4, 1, 0, 4, 0, 2, 5, 3, 6, 7, 4, 2};
    localparam logic [53:0] rst_note = {9'h000, LIS_M_DISC, 1'b1, 11'h000, 27'h7FFFFFF};

    always #50 clk = ~clk;

    lis_host_model lis_host_model_i (.clk, .ctrl_code, .ctrl_test_sel, .latch_strobe_n);

    lis_line_ctrl lis_line_ctrl_i (.clk, .rst, .ctrl_code, .ctrl_test_sel, .latch_strobe_n,
        .dev_reset_n, .loop_closure_det, .ring_trip_det, .ground_key_det, .thermal_hot,
        .battery_in_window, .line_mode, .supervision_status_n, .line_break_sw_on,
        .ring_access_sw_on, .scan_clamp_en, .loop_det_en, .thermal_sd_en,
        .low_batt_sd_en, .ac_tx_en, .dc_feed_en, .ring_trip_en, .onhook_tx_en,
        .tr_drive_en, .cm_det_en, .tip_open_en, .polarity_rev, .test_path_en,
        .test_tone_input_en, .test_level_output_oe, .test_level_sel);

    assign obs = {loop_det_en, thermal_sd_en, low_batt_sd_en, onhook_tx_en, tip_open_en,
                  test_path_en, test_level_sel,
                  line_mode, supervision_status_n, line_break_sw_on, ring_access_sw_on,
                  scan_clamp_en, ring_trip_en, dc_feed_en, ac_tx_en, tr_drive_en,
                  polarity_rev, cm_det_en, test_tone_input_en, test_level_output_oe};

    function automatic logic [53:0] exp_for(input logic [2:0] c, input logic [2:0] t);
        lis_mode_t   m;
        logic        act;
        logic        tst;
        logic        st;
        logic [26:0] k;
        // code to mode, unused codes disconnect
        case (c)
            `LIS_CODE_FWD:     m = LIS_M_FWD;
            `LIS_CODE_REV:     m = LIS_M_REV;
            `LIS_CODE_SCAN:    m = LIS_M_SCAN;
            `LIS_CODE_RING:    m = LIS_M_RING;
            `LIS_CODE_TIPOPEN: m = LIS_M_TIPOPEN;
            default:           m = LIS_M_DISC;
        endcase
        act = (m == LIS_M_FWD) || (m == LIS_M_REV);
        tst = (act || m == LIS_M_TIPOPEN) && t != `LIS_TSEL_NONE;
        case (m)
            LIS_M_DISC:    st = 1'b1;
            LIS_M_RING:    st = !ring_trip_det;
            LIS_M_TIPOPEN: st = !ground_key_det;
            default:       st = !loop_closure_det;
        endcase
        // bits the mode leaves open are not compared
        k = 27'h7FFFFFF;
        if (m == LIS_M_SCAN) k = k & ~27'h0000418;
        if (m == LIS_M_TIPOPEN) k = k & ~27'h0000478;
        if (act) k = k & ~27'h0000004;
        return {act || m == LIS_M_SCAN, m != LIS_M_DISC, m != LIS_M_DISC, act,
                m == LIS_M_TIPOPEN, tst, tst ? t : 3'h0,
                m, st, act, m == LIS_M_RING, m == LIS_M_SCAN, m == LIS_M_RING, act, act, act,
                m == LIS_M_REV, m == LIS_M_TIPOPEN, tst && t != `LIS_TSEL_VREF, tst, k};
    endfunction : exp_for

    task automatic expect_now(input logic [53:0] ek);
        @(negedge clk);
        notes_q.push_back(ek);
        -> smp;
    endtask : expect_now

    // capture on strobe fall, MBB_CYC settle for switch swaps
    task automatic go(input logic [2:0] c, input logic [2:0] t);
        @(posedge clk);
        {loop_closure_det, ring_trip_det, ground_key_det} <= 3'($urandom);
        lis_host_model_i.send(c, t, 3 + $urandom % 6);
        repeat (`LIS_MBB_CYC + 2) @(posedge clk);
        expect_now(exp_for(c, t));
    endtask : go

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    always @(smp) begin
        logic [53:0] ek;
        ek = notes_q.pop_front();
        `CHK(obs & ek[26:0], ek[53:27] & ek[26:0])
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("timeout");
        summarize();
    end

    initial begin
        void'($urandom(55));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        expect_now(rst_note);
        // direct swaps and swaps through disconnect
        foreach (seq[i]) go(seq[i], 3'h0);
        $display("test line states done");
        for (int t = 0; t < 8; t++) go(3'(1 + t % 2), 3'(t));
        go(`LIS_CODE_SCAN, `LIS_TSEL_VREF);
        go(`LIS_CODE_TIPOPEN, 3'h3);
        go(`LIS_CODE_RING, 3'h5);
        $display("test selections done");
        for (int k = 0; k < 2; k++) begin
            go(`LIS_CODE_FWD, 3'h0);
            @(posedge clk);
            if (k == 0) thermal_hot <= 1'b1;
            else battery_in_window <= 1'b0;
            repeat (6) @(posedge clk);
            expect_now({9'h000, LIS_M_FWD, 12'h000, 27'h7FFFFFF});
            @(posedge clk);
            thermal_hot <= 1'b0;
            battery_in_window <= 1'b1;
            repeat (6) @(posedge clk);
            expect_now(exp_for(`LIS_CODE_FWD, 3'h0));
        end
        $display("test shutdown done");
        @(posedge clk);
        dev_reset_n <= 1'b0;
        lis_host_model_i.send(`LIS_CODE_RING, 3'h0, 4);
        repeat (6) @(posedge clk);
        expect_now(rst_note);
        @(posedge clk);
        dev_reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        expect_now(rst_note);
        go(`LIS_CODE_REV, 3'h0);
        $display("test device reset done");
        @(posedge clk);
        summarize();
    end
endmodule : lis_line_ctrl_tb
